// >>> design/prescale_if.sv
`timescale 1ns/1ns
`default_nettype none
// Carries one prescaler request and its result pulse
interface prescale_if;
   logic       tick;      // Input pulse to second stage
   logic [1:0] div_sel;   // Second-stage divide code
   logic       out_tick;  // Output pulse
   modport user (output tick, output div_sel, input out_tick);
   modport stage (input tick, input div_sel, output out_tick);
endinterface : prescale_if
`default_nettype wire

// >>> design/prescale_stage.sv
`timescale 1ns/1ns
`default_nettype none
// Second prescaler stage: divides input pulses by 1, 2, 4 or 8
module prescale_stage
   import timebase_pkg::*;
(
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   prescale_if.stage  p
);
   logic [STAGE2_W-1:0] cnt_r;   // Pulse counter
   logic [STAGE2_W-1:0] cnt_nxt;
   logic [STAGE2_W-1:0] last;    // Terminal count for the code
   logic                hit;

   // Terminal count from the code: 0,1,3,7
   always_comb begin
      last = STAGE2_W'((1 << p.div_sel) - 1);
      hit  = p.tick && (cnt_r >= last);
      if (!p.tick) begin
         cnt_nxt = cnt_r;
      end else if (hit) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + STAGE2_W'(1);
      end
   end

   // Register the count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign p.out_tick = hit;   // Single-cycle pulse with the input tick, combinational

   a_div_count: assert property (@(posedge clk_i) disable iff (rst_i)
      p.out_tick |-> p.tick)
      else $error("stage output without input pulse");
endmodule : prescale_stage
`default_nettype wire

// >>> design/timebase_core.sv
// Functional notes
// - Decode exactly a 512-byte register window
// - Unimplemented locations in window read zero
// - Word access only, except interrupt flags
// - First stage divides clock by 4 or 32
// - Divide field gives 1, 2, 4, 8
// - First count every 32..256 or 4..32 clocks
// - Finest first-count resolution is four clocks
// - Gate bit picks pin clock or gate
// - Config holds interrupt level and vector
// - Gated: eighth clock counts while pin high
// - Second prescale gives clock/8 to /64
// - Emulation bit writable once after reset
// - Stop freezes counters, sets stopped flag
`timescale 1ns/1ns
`default_nettype none
module timebase_core
   import timebase_pkg::*;
#(
   parameter int CNT_W = 16   // Count register width
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Classic Wishbone slave, 32-bit data
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   // Second count external pin
   input  wire logic        t2_pin_i,
   // Channel event flags set by channel logic
   input  wire logic [15:0] chan_flag_set_i,
   // Interrupt assignment, emulation and count outputs to the system
   output logic      [2:0]  irq_level_o,
   output logic      [3:0]  irq_vector_o,
   output logic             emulation_o,
   output logic      [CNT_W-1:0] first_count_o,
   output logic      [CNT_W-1:0] second_count_o
);
   // Register state
   logic [15:0]      mcr_r, mcr_nxt;             // Module configuration
   logic [15:0]      icr_r, icr_nxt;             // Interrupt configuration
   logic [15:0]      cifr_r, cifr_nxt;           // Channel interrupt flags
   logic             emu_done_r, emu_done_nxt;   // Emulation bit already written
   logic             ack_r, ack_nxt;             // Bus acknowledge
   logic             err_r, err_nxt;             // Bus error
   logic [31:0]      rdat_r, rdat_nxt;           // Read data
   // Counters
   logic [PRE_W-1:0] pre1_r, pre1_nxt;           // First-stage divider
   logic [2:0]       pre8_r, pre8_nxt;           // Eighth-clock divider
   logic [CNT_W-1:0] first_timebase_count_r, first_timebase_count_nxt;           // First count
   logic [CNT_W-1:0] second_timebase_count_r, second_timebase_count_nxt;           // Second count
   logic [FILT_LEN-1:0] pin_sh_r, pin_sh_nxt;    // Pin sync and filter shift
   logic             pin_f_r, pin_f_nxt;         // Filtered pin level
   logic             pin_rise;                   // Filtered rising edge
   // Decode
   logic             req, in_win, word_ok, is_flag;
   logic [8:0]       ofs;
   logic             stopped;
   logic             tick1, tick8, tick2_in;

   prescale_if p1 ();   // First timebase second stage
   prescale_if p2 ();   // Second timebase prescaler

   prescale_stage u_p1 (.clk_i(clk_i), .rst_i(rst_i), .p(p1));
   prescale_stage u_p2 (.clk_i(clk_i), .rst_i(rst_i), .p(p2));

   // Address decode of the window
   always_comb begin
      req     = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
      in_win  = (wb_adr_i < 32'(WIN_BYTES));
      ofs     = wb_adr_i[8:0];
      is_flag = (ofs == OFS_CIFR);
      // Word access means both low lanes; flags also take single bytes
      word_ok = (wb_sel_i[1:0] == 2'h3) ||
                (is_flag && (wb_sel_i[1:0] != 2'h0));
   end

   assign stopped = mcr_r[B_STOP];

   // First stage: clock divided by 4 or 32; halted while stopped
   always_comb begin
      pre1_nxt = pre1_r;
      tick1    = 1'b0;
      if (!stopped) begin
         if (mcr_r[B_FIRST_STAGE_CLOCK_SELECT] ? (pre1_r >= PRE_W'(DIV_FAST - 1))
                           : (pre1_r >= PRE_W'(DIV_SLOW - 1))) begin
            pre1_nxt = '0;
            tick1    = 1'b1;   // Fastest is every 4 clocks
         end else begin
            pre1_nxt = pre1_r + PRE_W'(1);
         end
      end
   end

   // Eighth-clock source for the second count
   always_comb begin
      pre8_nxt = pre8_r;
      tick8    = 1'b0;
      if (!stopped) begin
         pre8_nxt = pre8_r + 3'h1;
         tick8    = (pre8_r == 3'(DIV_EIGHTH - 1));
      end
   end

   // Pin sync and digital filter: level changes after FILT_LEN-1 agreeing samples past the first sync stage
   always_comb begin
      pin_sh_nxt = {pin_sh_r[FILT_LEN-2:0], t2_pin_i};
      pin_f_nxt  = pin_f_r;
      if (pin_sh_r[FILT_LEN-1:1] == {(FILT_LEN-1){1'b1}}) begin
         pin_f_nxt = 1'b1;
      end else if (pin_sh_r[FILT_LEN-1:1] == {(FILT_LEN-1){1'b0}}) begin
         pin_f_nxt = 1'b0;
      end
      pin_rise = pin_f_nxt && !pin_f_r;
   end

   // Second count input select
   always_comb begin
      if (mcr_r[B_GATE]) begin
         tick2_in = tick8 && pin_f_r;
      end else begin
         tick2_in = pin_rise && !stopped;
      end
   end

   // Prescaler stage hookups
   assign p1.tick    = tick1;
   assign p1.div_sel = mcr_r[B_DIV1_HI:B_DIV1_LO];
   assign p2.tick    = tick2_in;
   assign p2.div_sel = mcr_r[B_DIV2_HI:B_DIV2_LO];

   // Count registers
   always_comb begin
      first_timebase_count_nxt = first_timebase_count_r;
      second_timebase_count_nxt = second_timebase_count_r;
      if (!stopped && p1.out_tick) begin
         first_timebase_count_nxt = first_timebase_count_r + CNT_W'(1);   // Wraps naturally
      end
      if (!stopped && p2.out_tick) begin
         second_timebase_count_nxt = second_timebase_count_r + CNT_W'(1);
      end
   end

   // Register writes, reads and acknowledge
   always_comb begin
      mcr_nxt      = mcr_r;
      icr_nxt      = icr_r;
      cifr_nxt     = cifr_r;
      emu_done_nxt = emu_done_r;
      ack_nxt      = 1'b0;
      err_nxt      = 1'b0;
      rdat_nxt     = rdat_r;
      if (req) begin
         if (!in_win || !word_ok) begin
            err_nxt = 1'b1;   // Outside window or illegal width
         end else begin
            ack_nxt  = 1'b1;
            rdat_nxt = 32'h0000_0000;   // Unused locations read zero
            unique case (ofs)
               OFS_MCR:  rdat_nxt = {16'h0000, mcr_r};
               OFS_ICR:  rdat_nxt = {16'h0000, icr_r};
               OFS_CIFR: rdat_nxt = {16'h0000, cifr_r};
               OFS_FIRST_TIMEBASE_COUNT: rdat_nxt = 32'(first_timebase_count_r);
               OFS_SECOND_TIMEBASE_COUNT: rdat_nxt = 32'(second_timebase_count_r);
               default:  rdat_nxt = 32'h0000_0000;
            endcase
            if (wb_we_i) begin
               unique case (ofs)
                  OFS_MCR: begin
                     mcr_nxt[B_STOP]              = wb_dat_i[B_STOP];
                     mcr_nxt[B_DIV2_HI:B_DIV2_LO] = wb_dat_i[B_DIV2_HI:B_DIV2_LO];
                     mcr_nxt[B_GATE]              = wb_dat_i[B_GATE];
                     mcr_nxt[B_FIRST_STAGE_CLOCK_SELECT]              = wb_dat_i[B_FIRST_STAGE_CLOCK_SELECT];
                     mcr_nxt[B_DIV1_HI:B_DIV1_LO] = wb_dat_i[B_DIV1_HI:B_DIV1_LO];
                     if (!emu_done_r) begin
                        mcr_nxt[B_EMU] = wb_dat_i[B_EMU];
                        emu_done_nxt   = 1'b1;
                     end
                  end
                  OFS_ICR: begin
                     icr_nxt = '0;
                     icr_nxt[B_LVL_HI:B_LVL_LO] = wb_dat_i[B_LVL_HI:B_LVL_LO];
                     icr_nxt[B_VEC_HI:B_VEC_LO] = wb_dat_i[B_VEC_HI:B_VEC_LO];
                  end
                  OFS_CIFR: begin
                     // Writing zero clears a flag, per enabled byte lane
                     if (wb_sel_i[0]) cifr_nxt[7:0]  = cifr_r[7:0]  & wb_dat_i[7:0];
                     if (wb_sel_i[1]) cifr_nxt[15:8] = cifr_r[15:8] & wb_dat_i[15:8];
                  end
                  default: ;
               endcase
            end
         end
      end
      // Stopped flag mirrors the halted clocks
      mcr_nxt[B_STF] = mcr_nxt[B_STOP];
      // New channel events win over a clearing write
      cifr_nxt = cifr_nxt | chan_flag_set_i;
   end

   // Registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mcr_r      <= MCR_RST;
         icr_r      <= ICR_RST;
         cifr_r     <= '0;
         emu_done_r <= 1'b0;
         ack_r      <= 1'b0;
         err_r      <= 1'b0;
         rdat_r     <= '0;
         pre1_r     <= '0;
         pre8_r     <= '0;
         first_timebase_count_r     <= '0;
         second_timebase_count_r     <= '0;
         pin_sh_r   <= '0;
         pin_f_r    <= 1'b0;
      end else begin
         mcr_r      <= mcr_nxt;
         icr_r      <= icr_nxt;
         cifr_r     <= cifr_nxt;
         emu_done_r <= emu_done_nxt;
         ack_r      <= ack_nxt;
         err_r      <= err_nxt;
         rdat_r     <= rdat_nxt;
         pre1_r     <= pre1_nxt;
         pre8_r     <= pre8_nxt;
         first_timebase_count_r     <= first_timebase_count_nxt;
         second_timebase_count_r     <= second_timebase_count_nxt;
         pin_sh_r   <= pin_sh_nxt;
         pin_f_r    <= pin_f_nxt;
      end
   end

   // Outputs
   assign wb_dat_o       = rdat_r;
   assign wb_ack_o       = ack_r;
   assign wb_err_o       = err_r;
   assign irq_level_o    = icr_r[B_LVL_HI:B_LVL_LO];
   assign irq_vector_o   = icr_r[B_VEC_HI:B_VEC_LO];
   assign emulation_o    = mcr_r[B_EMU];
   assign first_count_o  = first_timebase_count_r;
   assign second_count_o = second_timebase_count_r;

   // Checks
   a_stop_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
      stopped && $past(stopped) |-> $stable(first_timebase_count_r) && $stable(second_timebase_count_r))
      else $error("count moved while stopped");
   a_stf_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      mcr_r[B_STF] == mcr_r[B_STOP])
      else $error("stopped flag differs from stop bit");
   a_fast_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
      tick1 |=> !tick1 [*3])
      else $error("first stage pulse closer than four clocks");
   a_first_timebase_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
      !$stable(first_timebase_count_r) |-> first_timebase_count_r == $past(first_timebase_count_r) + CNT_W'(1))
      else $error("first count step not one");
   a_emu_once: assert property (@(posedge clk_i) disable iff (rst_i)
      emu_done_r && $past(emu_done_r) |-> $stable(mcr_r[B_EMU]))
      else $error("emulation bit changed twice");
   a_gate_block: assert property (@(posedge clk_i) disable iff (rst_i)
      mcr_r[B_GATE] && !pin_f_r |-> !p2.tick)
      else $error("gated count ran with pin low");
   a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      req && in_win && word_ok && !wb_we_i && ofs == 9'h100 |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
      else $error("unused location read nonzero");
   a_byte_refused: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !is_flag && wb_sel_i[1:0] == 2'h1 |=> wb_err_o && !wb_ack_o)
      else $error("byte access accepted on word register");
   a_window_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      req && wb_adr_i >= 32'(WIN_BYTES) |=> wb_err_o)
      else $error("access outside window acknowledged");
   // Helper for the slow period check: clocks since the last first-stage pulse
   logic [PRE_W:0]   gap_r, gap_nxt;             // Clocks since last pulse
   logic             gap_ok_r, gap_ok_nxt;       // Gap counted wholly in slow, running mode

   // Restart on every pulse; a mode change or a stop spoils the gap
   always_comb begin
      gap_nxt    = tick1 ? '0 : gap_r + (PRE_W+1)'(1);
      gap_ok_nxt = tick1 ? !mcr_r[B_FIRST_STAGE_CLOCK_SELECT] : (gap_ok_r && !mcr_r[B_FIRST_STAGE_CLOCK_SELECT] && !stopped);
   end

   // Register the helper
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gap_r    <= '0;
         gap_ok_r <= 1'b0;
      end else begin
         gap_r    <= gap_nxt;
         gap_ok_r <= gap_ok_nxt;
      end
   end

   a_slow_period: assert property (@(posedge clk_i) disable iff (rst_i)
      tick1 && gap_ok_r && !mcr_r[B_FIRST_STAGE_CLOCK_SELECT] |-> gap_r == (PRE_W+1)'(DIV_SLOW - 1))
      else $error("slow first stage period not 32");
endmodule : timebase_core
`default_nettype wire

// >>> design/timebase_pkg.sv
package timebase_pkg;
   // Register window
   localparam int          WIN_BYTES        = 512;
   localparam logic [8:0]  OFS_MCR          = 9'h000;   // Module configuration register
   localparam logic [8:0]  OFS_ICR          = 9'h008;   // Interrupt configuration register
   localparam logic [8:0]  OFS_CIFR         = 9'h020;   // Channel interrupt flag register
   localparam logic [8:0]  OFS_FIRST_TIMEBASE_COUNT         = 9'h030;   // First count, read only
   localparam logic [8:0]  OFS_SECOND_TIMEBASE_COUNT         = 9'h034;   // Second count, read only
   // Module configuration field positions
   localparam int          B_STOP           = 15;
   localparam int          B_DIV2_HI        = 14;
   localparam int          B_DIV2_LO        = 13;
   localparam int          B_STF            = 8;
   localparam int          B_EMU            = 7;
   localparam int          B_GATE           = 6;
   localparam int          B_FIRST_STAGE_CLOCK_SELECT           = 5;
   localparam int          B_DIV1_HI        = 1;
   localparam int          B_DIV1_LO        = 0;
   // Interrupt configuration fields
   localparam int          B_LVL_HI         = 10;
   localparam int          B_LVL_LO         = 8;
   localparam int          B_VEC_HI         = 7;
   localparam int          B_VEC_LO         = 4;
   // Reset values
   localparam logic [15:0] MCR_RST          = 16'h0000;
   localparam logic [15:0] ICR_RST          = 16'h0000;
   // Divide figures for the first stage and the eighth clock
   localparam int          DIV_FAST         = 4;
   localparam int          DIV_SLOW         = 32;
   localparam int          DIV_EIGHTH       = 8;
   localparam int          PRE_W            = 5;        // Wide enough for 32
   localparam int          STAGE2_W         = 3;        // Counts to 8
   // Pin sync and filter shift depth (one more than the samples that must agree)
   localparam int          FILT_LEN         = 3;
endpackage : timebase_pkg

// >>> verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import timebase_pkg::*;
   localparam int W = 8;                 // Narrow counts so a wrap fits in the run
   typedef struct packed {logic rd; logic err; logic [15:0] dat;} note_s;
   logic          clk_i          = 1'b0;
   logic          rst_i          = 1'b1;
   logic          wb_cyc_i       = 1'b0;
   logic          wb_stb_i       = 1'b0;
   logic          wb_we_i        = 1'b0;
   logic [31:0]   wb_adr_i       = 32'h0;
   logic [3:0]    wb_sel_i       = 4'h0;
   logic [31:0]   wb_dat_i       = 32'h0;
   logic          t2_pin_i       = 1'b0;
   logic [15:0]   chan_flag_set_i = 16'h0;
   logic [31:0]   wb_dat_o;
   logic          wb_ack_o;
   logic          wb_err_o;
   logic [2:0]    irq_level_o;
   logic [3:0]    irq_vector_o;
   logic          emulation_o;
   logic [W-1:0]  first_count_o;
   logic [W-1:0]  second_count_o;
   note_s         notes[$];              // Expected answers, oldest first
   note_s         nt;
   int            n_fail = 0;
   int            total_checks = 0;
   int            seed = 3;
   int            n;
   int            k;
   logic [15:0]   v;
   logic [W-1:0]  m;
   logic [W-1:0]  m2;

   // Free-running clock
   always #25 clk_i = ~clk_i;

   timebase_core #(.CNT_W(W)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .t2_pin_i(t2_pin_i), .chan_flag_set_i(chan_flag_set_i),
      .irq_level_o(irq_level_o), .irq_vector_o(irq_vector_o), .emulation_o(emulation_o),
      .first_count_o(first_count_o), .second_count_o(second_count_o));

   // Compare one value and count it
   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Verdict and end of run
   task automatic wrap_up;
      if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   // One classic cycle; the expected answer is queued first
   task automatic bus(input logic we, input logic [31:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat, input logic e, input logic [15:0] d);
      int i;
      notes.push_back('{~we, e, d});
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
      end
      if (i == 20) begin
         n_fail++;
         wrap_up();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : bus

   // Write the module configuration and read it back; emulation stays set
   task automatic wr_mcr(input logic [15:0] val, input logic st);
      bus(1'b1, OFS_MCR, 4'h3, {16'h0, val}, 1'b0, 16'h0);
      bus(1'b0, OFS_MCR, 4'h3, 32'h0, 1'b0, val | (16'h1 << B_EMU) | (16'(st) << B_STF));
   endtask : wr_mcr

   // Cycles between two successive count changes
   task automatic period(input logic sec, output int cyc);
      logic [W-1:0] last;
      int i;
      last = sec ? second_count_o : first_count_o;
      for (i = 0; i < 600 && (sec ? second_count_o : first_count_o) === last; i++) @(posedge clk_i);
      last = sec ? second_count_o : first_count_o;
      for (cyc = 0; cyc < 600 && (sec ? second_count_o : first_count_o) === last; cyc++) @(posedge clk_i);
   endtask : period

   // Answer watcher: takes the oldest note for each ack or err
   always @(posedge clk_i) begin
      if (rst_i === 1'b0 && (wb_ack_o === 1'b1 || wb_err_o === 1'b1)) begin
         if (notes.size() == 0) check("answer without request", 32'h1, 32'h0);
         else begin
            nt = notes.pop_front();
            check("error response", {31'h0, wb_err_o}, {31'h0, nt.err});
            if (nt.rd && !nt.err) check("read data", wb_dat_o, {16'h0, nt.dat});
         end
      end
   end

   // Main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, OFS_MCR, 4'h3, 32'h0, 1'b0, MCR_RST);
      bus(1'b0, OFS_ICR, 4'h3, 32'h0, 1'b0, ICR_RST);
      bus(1'b0, 32'h004, 4'h3, 32'h0, 1'b0, 16'h0);
      bus(1'b0, 32'h1FC, 4'h3, 32'h0, 1'b0, 16'h0);
      bus(1'b0, 32'h100, 4'h3, 32'h0, 1'b0, 16'h0);
      bus(1'b0, 32'h200, 4'h3, 32'h0, 1'b1, 16'h0);
      bus(1'b0, OFS_MCR, 4'h1, 32'h0, 1'b1, 16'h0);
      // Emulation accepts the first write only
      wr_mcr((16'h1 << B_EMU) | (16'h1 << B_FIRST_STAGE_CLOCK_SELECT), 1'b0);
      check("emulation", {31'h0, emulation_o}, 32'h1);
      wr_mcr(16'h1 << B_FIRST_STAGE_CLOCK_SELECT, 1'b0);
      check("emulation kept", {31'h0, emulation_o}, 32'h1);
      // Interrupt level and vector
      v = 16'($random(seed));
      bus(1'b1, OFS_ICR, 4'h3, {16'h0, v}, 1'b0, 16'h0);
      bus(1'b0, OFS_ICR, 4'h3, 32'h0, 1'b0, v & 16'h07F0);
      check("irq level", {29'h0, irq_level_o}, {29'h0, v[B_LVL_HI:B_LVL_LO]});
      check("irq vector", {28'h0, irq_vector_o}, {28'h0, v[B_VEC_HI:B_VEC_LO]});
      // First count rate for every select and divide code
      for (int p = 0; p < 2; p++) begin
         for (int d = 0; d < 4; d++) begin
            wr_mcr((16'(p) << B_FIRST_STAGE_CLOCK_SELECT) | 16'(d), 1'b0);
            period(1'b0, n);
            check("first period", n, (p ? DIV_FAST : DIV_SLOW) << d);
         end
      end
      // First count wraps from all ones to zero
      wr_mcr(16'h1 << B_FIRST_STAGE_CLOCK_SELECT, 1'b0);
      for (k = 0; k < 1100 && first_count_o !== {W{1'b1}}; k++) @(posedge clk_i);
      for (k = 0; k < 10 && first_count_o === {W{1'b1}}; k++) @(posedge clk_i);
      check("first wrap", {24'h0, first_count_o}, 32'h0);
      // Second count from the gated eighth clock
      t2_pin_i <= 1'b1;
      for (int d = 0; d < 4; d++) begin
         wr_mcr((16'h1 << B_GATE) | (16'(d) << B_DIV2_LO), 1'b0);
         period(1'b1, n);
         check("second period", n, DIV_EIGHTH << d);
      end
      t2_pin_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      m = second_count_o;
      repeat (100) @(posedge clk_i);
      check("gate closed", {24'h0, second_count_o}, {24'h0, m});
      // Second count clocked by the pin
      wr_mcr(16'h0, 1'b0);
      m = second_count_o;
      repeat (3) begin
         repeat (10) @(posedge clk_i);
         t2_pin_i <= 1'b1;
         repeat (10) @(posedge clk_i);
         t2_pin_i <= 1'b0;
      end
      repeat (10) @(posedge clk_i);
      check("pin edges", {24'h0, second_count_o}, {24'h0, W'(m + 3)});
      // Flag register: set, then byte-wide clear of the low half
      v = 16'($random(seed));
      @(posedge clk_i);
      chan_flag_set_i <= v;
      @(posedge clk_i);
      chan_flag_set_i <= 16'h0;
      bus(1'b0, OFS_CIFR, 4'h3, 32'h0, 1'b0, v);
      bus(1'b1, OFS_CIFR, 4'h1, 32'h0, 1'b0, 16'h0);
      bus(1'b0, OFS_CIFR, 4'h3, 32'h0, 1'b0, v & 16'hFF00);
      // Stop freezes both counts
      wr_mcr((16'h1 << B_STOP) | (16'h1 << B_FIRST_STAGE_CLOCK_SELECT) | (16'h1 << B_GATE), 1'b1);
      t2_pin_i <= 1'b1;
      m  = first_count_o;
      m2 = second_count_o;
      repeat (300) @(posedge clk_i);
      check("first frozen", {24'h0, first_count_o}, {24'h0, m});
      check("second frozen", {24'h0, second_count_o}, {24'h0, m2});
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
